//--- menu_navigator.sv
// keypad menu navigator: key debounce, menu levels, edit, save stepping and lamps
`timescale 1ns/1ps
`default_nettype none

// How it works
// (R1) four menu levels, monitoring up to edit
// (R2) five display modes selectable at mode selection
// (R3) reset starts at monitoring, first item
// (R4) back climbs to mode select, else steps down
// (R5) full mode: confirm to codes, then edit
// (R6) save only on confirm; full moves next
// (R7) shortcut save moves to next slot
// (R8) other modes step to their next code
// (R9) back at edit drops the pending value
// (R10) fresh shortcut slot shows first code, cursor low
// (R11) shortcut list is slots 0 to 31
// (R12) shift ignored at list-mode code selection
// (R13) modifiable code flashes lowest digit on entry
// (R14) changed list shows first differing code, steps
// (R15) fault view lists only fault record group
// (R16) shift cycles fault items during protection
// (R17) keypad control: run starts, stop clears fault
// (R18) direction lamp lit during reverse running
// (R19) run lamp steady, blinking on decel, off
// (R20) protection lamp lit in protection state
// (R21) unit lamps follow the displayed quantity
// (R22) knob turns step items, click goes up
// (R23) every key debounced, one pulse per press
module menu_navigator
  import menu_nav_pkg::*;
#(
  parameter int unsigned DEB_CYCLES   = DEBOUNCE_CYC,
  parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYC
) (
  input  wire logic [NUM_KEYS-1:0] keys_n,
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire drive_status_t       drive,
  input  wire logic [15:0]         store_rdata,
  input  wire logic                store_nondef,
  input  wire logic                store_modifiable,
  output var  disp_t               disp,
  output var  lamp_t               lamps,
  output logic [15:0]              query_code,
  output logic                     save_req,
  output logic [15:0]              save_code,
  output logic [15:0]              save_value,
  output logic                     run_req,
  output logic                     stop_req,
  output logic                     fault_clear
);

  // step a code inside its group or across the whole code space
  function automatic logic [15:0] step_code(input logic [15:0] c, input logic up,
                                            input logic one_group);
    logic [7:0] g;
    logic [7:0] i;
    g = c[15:8];
    i = c[7:0];
    if (up) begin
      if (i == INDEX_MAX) begin
        i = 8'h00;
        if (!one_group) g = (g == GROUP_MAX) ? 8'h00 : g + 8'h01;
      end else begin
        i = i + 8'h01;
      end
    end else begin
      if (i == 8'h00) begin
        i = INDEX_MAX;
        if (!one_group) g = (g == 8'h00) ? GROUP_MAX : g - 8'h01;
      end else begin
        i = i - 8'h01;
      end
    end
    return {g, i};
  endfunction

  // step a small item counter with wrap
  function automatic logic [2:0] step_item(input logic [2:0] v, input logic [2:0] n);
    return (v == n - 3'h1) ? 3'h0 : v + 3'h1;
  endfunction

  // debounce: each raw line must hold a new level for DEB_CYCLES before it is taken
  logic [NUM_KEYS-1:0] stable_r;
  logic [NUM_KEYS-1:0] press;
  genvar k;
  generate
    for (k = 0; k < NUM_KEYS; k++) begin : g_deb
      logic [31:0] cnt_r;
      wire         raw_pressed = ~keys_n[k];
      // any bounce restarts the settle window
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          cnt_r       <= 32'h0;
          stable_r[k] <= 1'b0;
        end else if (raw_pressed == stable_r[k]) begin
          cnt_r <= 32'h0;
        end else if (cnt_r >= DEB_CYCLES - 1) begin
          cnt_r       <= 32'h0;
          stable_r[k] <= raw_pressed; // [R23]
        end else begin
          cnt_r <= cnt_r + 32'h1;
        end
      end
      // one pulse on the debounced press edge only
      assign press[k] = (cnt_r >= DEB_CYCLES - 1) && raw_pressed && !stable_r[k]; // [R23]
    end
  endgenerate

  // registered key events, one cycle each
  key_evt_t ev_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) ev_r <= '0;
    else         ev_r <= press; // [R23]
  end

  // menu state
  level_t      level_r;
  mode_t       mode_r;
  logic [15:0] code_r;
  logic [15:0] edit_r;
  logic [1:0]  cursor_r;
  logic        flash_r;
  logic [2:0]  mon_item_r;
  logic [2:0]  fault_item_r;
  logic        search_r;
  logic        search_up_r;
  logic        search_skip_r;
  logic [15:0] search_cnt_r;

  // mode-dependent decoding used by several branches
  wire is_full   = (mode_r == MODE_FULL);
  wire is_short  = (mode_r == MODE_SHORTCUT);
  wire is_nondef = (mode_r == MODE_NONDEF);
  wire is_fault  = (mode_r == MODE_FAULT);
  wire knob_turn = ev_r.cw | ev_r.ccw;
  wire step_lvl  = ev_r.click; // [R22]
  wire list_mode = is_short | is_nondef | is_fault;
  wire [4:0] mode_up = {mode_r[3:0], mode_r[4]};
  wire [4:0] mode_dn = {mode_r[0], mode_r[4:1]};

  // neighbours wrap at both ends
  wire [7:0] slot_up = (code_r[7:0] == SHORTCUT_SLOTS - 8'h01) ? 8'h00 : code_r[7:0] + 8'h01;
  wire [7:0] slot_dn = (code_r[7:0] == 8'h00) ? SHORTCUT_SLOTS - 8'h01 : code_r[7:0] - 8'h01;
  wire [7:0] grp_up  = (code_r[15:8] == GROUP_MAX) ? 8'h00 : code_r[15:8] + 8'h01;
  wire [7:0] grp_dn  = (code_r[15:8] == 8'h00) ? GROUP_MAX : code_r[15:8] - 8'h01;

  // digit weight and neighbouring codes
  wire [15:0] digit  = 16'h0001 << {cursor_r, 2'b00};
  wire [15:0] code_fwd_grp = step_code(code_r, 1'b1, 1'b1);
  wire [15:0] code_fwd_all = step_code(code_r, 1'b1, 1'b0);
  wire [15:0] code_knob_grp = step_code(code_r, ev_r.cw, 1'b1);
  wire [15:0] code_knob_all = step_code(code_r, ev_r.cw, 1'b0);

  // a save skips its own code in the scan
  wire search_hit  = !search_skip_r && store_nondef;
  wire search_over = (search_cnt_r == SEARCH_LIMIT);
  wire can_save    = flash_r && step_lvl;

  // menu state machine; the nondefault search owns the code while it runs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level_r       <= LVL_MONITOR; // [R3]
      mode_r        <= MODE_FULL;
      code_r        <= FIRST_FUNCTION_CODE;
      edit_r        <= 16'h0000;
      cursor_r      <= 2'h0;
      flash_r       <= 1'b0;
      mon_item_r    <= 3'h0; // [R3]
      fault_item_r  <= 3'h0;
      search_r      <= 1'b0;
      search_up_r   <= 1'b1;
      search_skip_r <= 1'b0;
      search_cnt_r  <= 16'h0000;
      save_req      <= 1'b0;
      save_code     <= 16'h0000;
      save_value    <= 16'h0000;
    end else begin
      save_req <= 1'b0;
      if (search_r) begin
        // keys are ignored while scanning, the scan ends within SEARCH_LIMIT + 1 cycles
        if (search_hit || search_over) begin
          search_r <= 1'b0; // [R14]
        end else begin
          code_r        <= step_code(code_r, search_up_r, 1'b0); // [R14]
          search_skip_r <= 1'b0;
          search_cnt_r  <= search_cnt_r + 16'h0001;
        end
      end else begin
        unique case (level_r)
          LVL_MONITOR: begin
            if (ev_r.back) level_r <= LVL_MODESEL; // [R4] [R1]
            else if (ev_r.right) mon_item_r <= step_item(mon_item_r, MON_ITEMS);
          end
          LVL_MODESEL: begin
            if (ev_r.back) begin
              level_r <= LVL_MONITOR; // [R4]
            end else if (knob_turn) begin
              mode_r <= mode_t'(ev_r.cw ? mode_up : mode_dn); // [R4] [R2] [R22]
            end else if (step_lvl) begin
              level_r  <= LVL_CODESEL; // [R5]
              cursor_r <= 2'h0;
              unique case (mode_r)
                MODE_FULL:     code_r <= FIRST_FUNCTION_CODE;
                MODE_SHORTCUT: code_r <= {SHORTCUT_SLOT_GROUP, 8'h00}; // [R11]
                MODE_FAULT:    code_r <= {FAULT_RECORD_GROUP, 8'h00}; // [R15]
                MODE_VERSION:  code_r <= {VERSION_GROUP, 8'h00};
                MODE_NONDEF: begin
                  code_r        <= FIRST_FUNCTION_CODE; // [R14]
                  search_r      <= 1'b1;
                  search_up_r   <= 1'b1;
                  search_skip_r <= 1'b0;
                  search_cnt_r  <= 16'h0000;
                end
              endcase
            end
          end
          LVL_CODESEL: begin
            if (ev_r.back) begin
              level_r <= LVL_MODESEL; // [R4]
            end else if (step_lvl) begin
              level_r  <= LVL_EDIT; // [R5] [R22]
              edit_r   <= store_rdata; // [R10]
              cursor_r <= 2'h0; // [R10] [R13]
              flash_r  <= store_modifiable; // [R13]
              fault_item_r <= 3'h0;
            end else if (ev_r.right && !list_mode) begin
              cursor_r <= {1'b0, ~cursor_r[0]}; // [R12] full mode picks group or index
            end else if (knob_turn) begin
              if (is_short) begin
                code_r[7:0] <= ev_r.cw ? slot_up : slot_dn; // [R11]
              end else if (is_nondef) begin
                code_r        <= code_knob_all; // [R14]
                search_r      <= 1'b1;
                search_up_r   <= ev_r.cw;
                search_skip_r <= 1'b0;
                search_cnt_r  <= 16'h0000;
              end else if (is_full && cursor_r[0]) begin
                code_r[15:8] <= ev_r.cw ? grp_up : grp_dn; // [R22]
              end else if (is_full) begin
                code_r <= code_knob_all; // [R22]
              end else begin
                code_r <= code_knob_grp; // [R15]
              end
            end
          end
          LVL_EDIT: begin
            if (ev_r.back) begin
              level_r <= LVL_CODESEL; // [R9] pending edit_r is simply dropped
              flash_r <= 1'b0;
              cursor_r <= 2'h0; // stale edit cursor would steer the knob
            end else if (can_save) begin
              save_req   <= 1'b1; // [R6]
              save_code  <= code_r;
              save_value <= edit_r;
              level_r    <= LVL_CODESEL;
              cursor_r   <= 2'h0;
              flash_r    <= 1'b0;
              unique case (mode_r)
                MODE_FULL:     code_r <= code_fwd_all; // [R6]
                MODE_SHORTCUT: code_r[7:0] <= slot_up; // [R7]
                MODE_FAULT:    code_r <= code_fwd_grp; // [R8]
                MODE_VERSION:  code_r <= code_fwd_grp; // [R8]
                MODE_NONDEF: begin
                  search_r      <= 1'b1; // [R8]
                  search_up_r   <= 1'b1;
                  search_skip_r <= 1'b1;
                  search_cnt_r  <= 16'h0000;
                end
              endcase
            end else if (ev_r.right && is_fault && drive.protection) begin
              fault_item_r <= step_item(fault_item_r, FAULT_ITEMS); // [R16]
            end else if (ev_r.right && flash_r) begin
              cursor_r <= (cursor_r == CURSOR_MAX) ? 2'h0 : cursor_r + 2'h1; // [R13]
            end else if (knob_turn && flash_r) begin
              edit_r <= ev_r.cw ? edit_r + digit : edit_r - digit; // [R22] [R13]
            end
          end
        endcase
      end
    end
  end

  // run, stop and reset requests from the keypad when it owns the command source
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_req     <= 1'b0;
      stop_req    <= 1'b0;
      fault_clear <= 1'b0;
    end else begin
      run_req     <= drive.keypad_ctrl && ev_r.run && !drive.protection; // [R17]
      stop_req    <= drive.keypad_ctrl && ev_r.stop; // [R17]
      fault_clear <= drive.keypad_ctrl && ev_r.stop && drive.protection; // [R17]
    end
  end

  // blink enable divider; a slow toggle is cheaper than a wide phase compare
  logic [31:0] blink_cnt_r;
  logic        blink_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blink_cnt_r <= 32'h0;
      blink_r     <= 1'b0;
    end else if (blink_cnt_r >= BLINK_CYCLES - 1) begin
      blink_cnt_r <= 32'h0;
      blink_r     <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h1;
    end
  end

  // which quantity is on the display decides the unit lamp
  // items past voltage light no unit lamp
  wire       fault_shown = (level_r == LVL_EDIT) && is_fault && drive.protection;
  wire [2:0] shown_item  = fault_shown ? fault_item_r :
                           (level_r == LVL_MONITOR) ? mon_item_r + 3'h1 : 3'h0;

  // lamps are registered so every lamp pin comes from a flop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lamps <= '0;
    end else begin
      lamps.unit_hz   <= (shown_item == ITEM_FREQ); // [R21]
      lamps.unit_a    <= (shown_item == ITEM_CURRENT); // [R21]
      lamps.unit_v    <= (shown_item == ITEM_VOLTAGE); // [R21]
      lamps.reverse_direction_lamp <= drive.running && drive.reverse; // [R18]
      lamps.run_lamp  <= drive.running && (!drive.decelerating || blink_r); // [R19]
      lamps.protect_lamp <= drive.protection; // [R20]
    end
  end

  // display and store address are the state flops themselves
  assign disp = '{level: level_r, mode: mode_r, code: code_r, value: edit_r,
                  cursor: cursor_r, flash: flash_r, mon_item: mon_item_r,
                  fault_item: fault_item_r, busy: search_r};
  assign query_code = code_r;

endmodule

`default_nettype wire

//--- menu_nav_pkg.sv
// shared constants, state codes and carrier types of the keypad menu navigator
package menu_nav_pkg;

  // timing at the 40 MHz system clock
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned DEBOUNCE_NS     = 5_000_000;   // 5 ms contact settle time
  localparam int unsigned DEBOUNCE_CYC    = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLINK_HALF_NS   = 250_000_000; // 250 ms lamp blink half period
  localparam int unsigned BLINK_HALF_CYC  = BLINK_HALF_NS / CLK_PERIOD_NS;

  // key bit positions in the raw key vector
  localparam int unsigned NUM_KEYS = 7;
  localparam int unsigned K_RIGHT  = 0;
  localparam int unsigned K_BACK   = 1;
  localparam int unsigned K_RUN    = 2;
  localparam int unsigned K_STOP   = 3;
  localparam int unsigned K_CW     = 4;
  localparam int unsigned K_CCW    = 5;
  localparam int unsigned K_CLICK  = 6;

  // function code space, a code is {group, index}
  localparam logic [7:0]  GROUP_MAX          = 8'h1F;
  localparam logic [7:0]  INDEX_MAX          = 8'h63;
  localparam logic [15:0] FIRST_FUNCTION_CODE = 16'h0000;
  localparam logic [7:0]  SHORTCUT_SLOT_GROUP = 8'h0B;
  localparam logic [7:0]  FAULT_RECORD_GROUP  = 8'h13;
  localparam logic [7:0]  VERSION_GROUP       = 8'h1A;
  localparam logic [7:0]  SHORTCUT_SLOTS      = 8'h20;  // 32 slots, 0..31
  localparam logic [15:0] SEARCH_LIMIT        = 16'h2000;

  // display items and cursor range
  localparam logic [2:0]  MON_ITEMS   = 3'h5;
  localparam logic [2:0]  FAULT_ITEMS = 3'h5;
  localparam logic [1:0]  CURSOR_MAX  = 2'h3;

  // unit lamp items shared by monitoring and fault view
  localparam logic [2:0]  ITEM_FREQ    = 3'h1;
  localparam logic [2:0]  ITEM_CURRENT = 3'h2;
  localparam logic [2:0]  ITEM_VOLTAGE = 3'h3;

  typedef enum logic [3:0] {
    LVL_MONITOR = 4'h1,
    LVL_MODESEL = 4'h2,
    LVL_CODESEL = 4'h4,
    LVL_EDIT    = 4'h8
  } level_t;

  typedef enum logic [4:0] {
    MODE_FULL     = 5'h01,
    MODE_SHORTCUT = 5'h02,
    MODE_NONDEF   = 5'h04,
    MODE_FAULT    = 5'h08,
    MODE_VERSION  = 5'h10
  } mode_t;

  typedef struct packed {
    logic click;
    logic ccw;
    logic cw;
    logic stop;
    logic run;
    logic back;
    logic right;
  } key_evt_t;

  typedef struct packed {
    logic keypad_ctrl;
    logic running;
    logic decelerating;
    logic reverse;
    logic protection;
  } drive_status_t;

  typedef struct packed {
    logic unit_hz;
    logic unit_a;
    logic unit_v;
    logic reverse_direction_lamp;
    logic run_lamp;
    logic protect_lamp;
  } lamp_t;

  typedef struct packed {
    level_t      level;
    mode_t       mode;
    logic [15:0] code;
    logic [15:0] value;
    logic [1:0]  cursor;
    logic        flash;
    logic [2:0]  mon_item;
    logic [2:0]  fault_item;
    logic        busy;
  } disp_t;

endpackage

//--- menu_navigator_checker.sv
// assertion checker for the keypad menu navigator, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module menu_navigator_checker
  import menu_nav_pkg::*;
#(
  parameter int unsigned DEB_CYCLES   = DEBOUNCE_CYC,
  parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYC
) (
  input wire logic [NUM_KEYS-1:0] keys_n,
  input wire logic                clk,
  input wire logic                resetn,
  input wire drive_status_t       drive,
  input wire logic [15:0]         store_rdata,
  input wire logic                store_nondef,
  input wire logic                store_modifiable,
  input wire disp_t               disp,
  input wire lamp_t               lamps,
  input wire logic [15:0]         query_code,
  input wire logic                save_req,
  input wire logic [15:0]         save_code,
  input wire logic [15:0]         save_value,
  input wire logic                run_req,
  input wire logic                stop_req,
  input wire logic                fault_clear
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // menu level moves: monitoring opens mode selection only, edit only from codes
  a_mon_exit: assert property (
    $past(disp.level) == LVL_MONITOR && disp.level != LVL_MONITOR |-> disp.level == LVL_MODESEL)
    else $error("monitoring left to a wrong level");
  a_edit_entry: assert property (
    $changed(disp.level) && disp.level == LVL_EDIT |-> $past(disp.level) == LVL_CODESEL)
    else $error("edit level entered from a wrong level");
  // a save comes only out of the edit level and its payload only moves with it
  a_save_source: assert property (
    save_req |-> $past(disp.level) == LVL_EDIT || $past(disp.level, 2) == LVL_EDIT)
    else $error("save outside the edit level");
  a_save_hold: assert property (
    $changed(save_code) || $changed(save_value) |-> save_req)
    else $error("save payload moved without a save");
  // shortcut and fault modes keep the code inside their own group
  a_slot_range: assert property (
    disp.mode == MODE_SHORTCUT && disp.level == LVL_CODESEL && !disp.busy
    |-> disp.code[15:8] == SHORTCUT_SLOT_GROUP && disp.code[7:0] < SHORTCUT_SLOTS)
    else $error("shortcut slot out of range");
  a_fault_group: assert property (
    disp.mode == MODE_FAULT && disp.level == LVL_CODESEL |-> disp.code[15:8] == FAULT_RECORD_GROUP)
    else $error("fault view left its group");
  // drive requests
  a_run_gate: assert property (
    run_req |-> $past(drive.keypad_ctrl) && !$past(drive.protection))
    else $error("run requested without keypad control or in protection");
  a_clear_stop: assert property (
    fault_clear |-> stop_req)
    else $error("fault clear without a stop request");
  a_one_pulse: assert property (
    run_req |=> !run_req)
    else $error("run request longer than one cycle");
  // lamps follow the drive one edge later
  a_rev_lamp: assert property (
    $past(resetn) |-> lamps.reverse_direction_lamp == $past(drive.running & drive.reverse))
    else $error("direction lamp wrong");
  a_prot_lamp: assert property (
    $past(resetn) |-> lamps.protect_lamp == $past(drive.protection))
    else $error("protection lamp wrong");
  a_run_lamp: assert property (
    $past(resetn) && !$past(drive.decelerating) |-> lamps.run_lamp == $past(drive.running))
    else $error("running lamp wrong");

  // main scenarios reached
  c_save: cover property (save_req);
  c_clear: cover property (fault_clear);
  c_slot_edit: cover property (disp.level == LVL_EDIT && disp.mode == MODE_SHORTCUT);
endmodule

bind menu_navigator menu_navigator_checker #(
  .DEB_CYCLES(DEB_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) chk (
  .keys_n(keys_n), .clk(clk), .resetn(resetn), .drive(drive), .store_rdata(store_rdata),
  .store_nondef(store_nondef), .store_modifiable(store_modifiable), .disp(disp),
  .lamps(lamps), .query_code(query_code), .save_req(save_req), .save_code(save_code),
  .save_value(save_value), .run_req(run_req), .stop_req(stop_req), .fault_clear(fault_clear));
`default_nettype wire

//--- keypad_operator.sv
// operator model: presses keys and turns the knob with contact bounce
`timescale 1ns/1ps
`default_nettype none
module keypad_operator
  import menu_nav_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = 4
) (
  input  wire logic                clk,
  output var  logic [NUM_KEYS-1:0] keys_n
);
  // released contacts are pulled high
  initial keys_n = '1;

  // one bounce shorter than the settle time, then a clean hold and release
  task automatic press(input int unsigned k);
    @(negedge clk) keys_n[k] = 1'b0;
    @(negedge clk) keys_n[k] = 1'b1;
    @(negedge clk) keys_n[k] = 1'b0;
    repeat (DEB_CYCLES + 4) @(negedge clk);
    keys_n[k] = 1'b1;
    repeat (DEB_CYCLES + 4) @(negedge clk);
  endtask
endmodule
`default_nettype wire

//--- menu_navigator_tb.sv
// self-checking bench for the keypad menu navigator
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("[ERR] %s exp=%h got=%h", nm, e, g); \
  end \
end
module menu_navigator_tb;
  import menu_nav_pkg::*;
  logic                clk = 1'b0;
  logic                resetn = 1'b0;
  logic [NUM_KEYS-1:0] keys_n;
  drive_status_t       drive = '0;
  logic [15:0]         store_rdata, query_code, save_code, save_value;
  logic                store_nondef, store_modifiable, save_req, run_req, stop_req, fault_clear;
  disp_t               disp;
  lamp_t               lamps;
  int                  n_fail = 0, check_count = 0, n_save = 0, n_run = 0, n_stop = 0, n_clr = 0;

  always #12.5 clk = ~clk;
  // store: slots read as the first code, two codes differ from default, version is locked
  assign store_rdata = (query_code[15:8] == SHORTCUT_SLOT_GROUP) ? FIRST_FUNCTION_CODE
                       : {query_code[7:0], 8'h11};
  assign store_nondef = (query_code == 16'h0003) || (query_code == 16'h0007);
  assign store_modifiable = (query_code[15:8] != VERSION_GROUP);
  // pulses are one cycle wide, so they are counted as they pass
  always @(posedge clk) begin
    if (save_req === 1'b1) n_save++;
    if (run_req === 1'b1) n_run++;
    if (stop_req === 1'b1) n_stop++;
    if (fault_clear === 1'b1) n_clr++;
  end

  keypad_operator #(.DEB_CYCLES(4)) op (.clk(clk), .keys_n(keys_n));
  menu_navigator #(.DEB_CYCLES(4), .BLINK_CYCLES(8)) dut (
    .keys_n(keys_n), .clk(clk), .resetn(resetn), .drive(drive), .store_rdata(store_rdata),
    .store_nondef(store_nondef), .store_modifiable(store_modifiable), .disp(disp),
    .lamps(lamps), .query_code(query_code), .save_req(save_req), .save_code(save_code),
    .save_value(save_value), .run_req(run_req), .stop_req(stop_req), .fault_clear(fault_clear));

  // keys are lost during a scan, so every step waits it out
  task automatic idle();
    for (int i = 0; i < 200 && disp.busy !== 1'b0; i++) @(negedge clk);
    `CHK("busy", 1'b0, disp.busy)
  endtask
  task automatic go(input mode_t m);
    op.press(K_BACK);
    for (int i = 0; i < 5 && disp.mode !== m; i++) op.press(K_CW);
    op.press(K_CLICK);
    idle();
  endtask
  task automatic home();
    for (int i = 0; i < 3 && disp.level !== LVL_MONITOR; i++) op.press(K_BACK);
  endtask

  task automatic t_modes();
    logic [4:0] seen;
    mode_t      m4;
    seen = '0;
    `CHK("level", LVL_MONITOR, disp.level)
    `CHK("mon_item", 3'h0, disp.mon_item)
    op.press(K_RIGHT);
    `CHK("mon_next", 3'h1, disp.mon_item)
    `CHK("mon_amp", 1'b1, lamps.unit_a)
    op.press(K_BACK);
    `CHK("modesel", LVL_MODESEL, disp.level)
    for (int i = 0; i < 5; i++) begin
      op.press(K_CW);
      seen = seen | disp.mode;
      if (i == 3) m4 = disp.mode;
    end
    `CHK("modes", 5'h1F, seen)
    `CHK("wrap", MODE_FULL, disp.mode)
    op.press(K_CCW);
    `CHK("ccw", m4, disp.mode)
    op.press(K_BACK);
    `CHK("back", LVL_MONITOR, disp.level)
  endtask

  task automatic t_full();
    go(MODE_FULL);
    `CHK("first", FIRST_FUNCTION_CODE, disp.code)
    op.press(K_CW);
    op.press(K_CLICK);
    `CHK("edit", LVL_EDIT, disp.level)
    `CHK("value", 16'h0111, disp.value)
    `CHK("flash", 1'b1, disp.flash)
    op.press(K_CW);
    `CHK("inc", 16'h0112, disp.value)
    op.press(K_RIGHT);
    op.press(K_CW);
    `CHK("digit1", 16'h0122, disp.value)
    op.press(K_BACK);
    `CHK("nosave", 0, n_save)
    `CHK("cur_back", 2'h0, disp.cursor)
    op.press(K_CLICK);
    `CHK("kept", 16'h0111, disp.value)
    op.press(K_CCW);
    op.press(K_CLICK);
    `CHK("saves", 1, n_save)
    `CHK("s_code", 16'h0001, save_code)
    `CHK("s_val", 16'h0110, save_value)
    `CHK("next", 16'h0002, disp.code)
    `CHK("query", 16'h0002, query_code)
    home();
  endtask

  task automatic t_short();
    go(MODE_SHORTCUT);
    `CHK("slot0", {SHORTCUT_SLOT_GROUP, 8'h00}, disp.code)
    op.press(K_CCW);
    `CHK("slot31", {SHORTCUT_SLOT_GROUP, 8'h1F}, disp.code)
    op.press(K_RIGHT);
    `CHK("cursor", 2'h0, disp.cursor)
    op.press(K_CW);
    op.press(K_CLICK);
    `CHK("default", FIRST_FUNCTION_CODE, disp.value)
    `CHK("lowdig", 2'h0, disp.cursor)
    op.press(K_CW);
    op.press(K_CLICK);
    `CHK("saves", 2, n_save)
    `CHK("slot1", {SHORTCUT_SLOT_GROUP, 8'h01}, disp.code)
    home();
  endtask

  task automatic t_nondef();
    go(MODE_NONDEF);
    `CHK("diff1", 16'h0003, disp.code)
    op.press(K_CW);
    idle();
    `CHK("diff2", 16'h0007, disp.code)
    op.press(K_CCW);
    idle();
    `CHK("diff0", 16'h0003, disp.code)
    `CHK("nowrite", 2, n_save)
    op.press(K_CLICK);
    op.press(K_CW);
    op.press(K_CLICK);
    idle();
    `CHK("saves", 3, n_save)
    `CHK("after", 16'h0007, disp.code)
    home();
  endtask

  task automatic t_fault();
    logic [2:0] e;
    go(MODE_FAULT);
    `CHK("fgrp", {FAULT_RECORD_GROUP, 8'h00}, disp.code)
    op.press(K_RIGHT);
    `CHK("noshift", 2'h0, disp.cursor)
    op.press(K_CW);
    `CHK("fnext", {FAULT_RECORD_GROUP, 8'h01}, disp.code)
    op.press(K_CLICK);
    drive.protection = 1'b1;
    e = ITEM_FREQ;
    op.press(K_RIGHT);
    `CHK("fitem", e, disp.fault_item)
    `CHK("hz", e == ITEM_FREQ, lamps.unit_hz)
    `CHK("amp", e == ITEM_CURRENT, lamps.unit_a)
    `CHK("volt", e == ITEM_VOLTAGE, lamps.unit_v)
    drive.protection = 1'b0;
    home();
    go(MODE_VERSION);
    `CHK("ver", {VERSION_GROUP, 8'h00}, disp.code)
    op.press(K_CLICK);
    `CHK("locked", 1'b0, disp.flash)
    op.press(K_CLICK);
    `CHK("nosave", 3, n_save)
    home();
  endtask

  task automatic t_drive();
    logic [1:0] seen;
    seen = '0;
    drive.keypad_ctrl = 1'b1;
    op.press(K_RUN);
    `CHK("run", 1, n_run)
    drive.protection = 1'b1;
    op.press(K_RUN);
    `CHK("refused", 1, n_run)
    op.press(K_STOP);
    `CHK("stop", 1, n_stop)
    `CHK("clear", 1, n_clr)
    `CHK("red", 1'b1, lamps.protect_lamp)
    drive = '0;
    op.press(K_RUN);
    `CHK("nokeypad", 1, n_run)
    drive.running = 1'b1;
    drive.reverse = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("rev", 1'b1, lamps.reverse_direction_lamp)
    `CHK("runlamp", 1'b1, lamps.run_lamp)
    drive.reverse = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("fwd", 1'b0, lamps.reverse_direction_lamp)
    drive.decelerating = 1'b1;
    repeat (24) begin
      @(negedge clk);
      seen[lamps.run_lamp] = 1'b1;
    end
    `CHK("blink", 2'b11, seen)
    drive = '0;
    repeat (2) @(negedge clk);
    `CHK("off", 1'b0, lamps.run_lamp)
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // main sequence after a five-cycle reset
  initial begin
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    t_modes();
    t_full();
    t_short();
    t_nondef();
    t_fault();
    t_drive();
    final_report();
  end
  // watchdog: the run needs about 1300 cycles
  initial begin
    repeat (10000) @(posedge clk);
    n_fail++;
    final_report();
  end
endmodule
`default_nettype wire
